//--- hdl/ptwc_pkg.sv
// Constants for the port trigger and watchdog control block
package ptwc_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_PORT_CFG = 8'h1b;
  localparam logic [7:0] REG_LATCH_CFG = 8'h1d;
  localparam logic [7:0] REG_IRQ_SRC_CFG = 8'h1e;
  localparam logic [7:0] REG_DIR_PU_CFG = 8'h21;
  localparam logic [7:0] REG_BG_CFG = 8'h22;
  localparam logic [7:0] REG_WDT_KEY = 8'h23;
  localparam logic [7:0] REG_STATUS = 8'h24;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_PULSE_OUT_0_SEL = 0;
  localparam int BIT_PULSE_OUT_1_SEL = 1;
  localparam int SPEED_LSB = 4;
  localparam int DEB_EN_LSB = 6;
  localparam int LATCH_MASK_LSB = 0;
  localparam int TRIG_PIN_LSB = 4;
  localparam int SRC_EN_LSB = 0;
  localparam int SRC_CAP = 0;
  localparam int SRC_RES = 1;
  localparam int SRC_TIMER = 2;
  localparam int BIT_IRQ4_EN = 6;
  localparam int BIT_IRQ5_EN = 7;
  localparam int PU_LSB = 0;
  localparam int DIR_LSB = 4;
  localparam int BIT_BG_EN = 0;
  // ----------------------------------------------------------------
  // Reset values and keys
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PORT_CFG = 8'h20;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_DIR_PU = 8'hf0;
  localparam logic [7:0] WDT_KEY = 8'h5a;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int DEB_MS = 40;
  localparam int DEB_CYCLES_DEF = DEB_MS * (CLK_HZ / 1000);
  localparam int DEB_W = 21;
  // Low-frequency oscillator rate is assumed; shortest timeout is used
  localparam int LF_OSC_HZ = 10000;
  localparam int WDT_MIN_S = 9;
  localparam int WDT_TICKS_DEF = WDT_MIN_S * LF_OSC_HZ;
  localparam int WDT_W = 17;
  // ----------------------------------------------------------------
  // Watchdog states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PTWC_WDT_ARMED = 2'b01,
    PTWC_WDT_OFF = 2'b10
  } ptwc_wdt_t;
endpackage

//--- hdl/ptwc_top.sv
// Port trigger, processor start and watchdog control
// Notes on behaviour
// - Input pins 0 and 1 may use a 40 ms monoflop debounce filter.
// - Config bits 6 and 7 enable debounce on pin 0 and pin 1.
// - Pulse selects route pulse 0 to pin 0 or 2, pulse 1 to 1 or 3.
// - Latch mask bits 0..3 enable the trigger latch of pins 0..3.
// - Bits 6 and 7 put the low interrupt onto pin 4 or pin 5.
// - Direction bits 4..7: zero drives pins 0..3, one makes them inputs.
// - Pull-up bits 0..3 enable pull-ups on pins 0..3.
// - Two-bit speed field: fastest, fast, recommended, slow low-current.
// - Trigger pin select picks which of four latches starts the processor.
// - Source enables: capacitance end, resistance end, timer; bit 3 unused.
// - With refresh enabled every processor start also refreshes the bandgap.
// - Start-conversion or trigger command from the host starts the processor.
// - Selected latch starts the processor; firmware clears it by set-then-clear.
// - Run bit rising and conversion ends start it, with active-low flags.
// - Watchdog counts low-frequency ticks while armed, even while halted.
// - Without restart within the timeout: reset pulse, flag set.
// - Falling edge on enabled input sets its latch; held until reset, stop or firmware clear.
// - Interrupt write gives a single self-clearing pulse on the pin.
`timescale 1ns/1ps
`default_nettype none
module ptwc_top
  import ptwc_pkg::*;
#(
  parameter int DEB_CYCLES = ptwc_pkg::DEB_CYCLES_DEF,
  parameter int WDT_TICKS = ptwc_pkg::WDT_TICKS_DEF
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic cfg_we,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic [3:0] gpio_in,
  output logic [3:0] gpio_out,
  output logic [3:0] gpio_oe,
  output logic [3:0] gpio_pu,
  output logic gpio_pin_4,
  output logic gpio_pin_5,
  input wire logic pulse_out_0,
  input wire logic pulse_out_1,
  input wire logic [5:0] proc_out_bits,
  input wire logic irq_write,
  input wire logic proc_stop,
  input wire logic start_conv_cmd,
  input wire logic proc_trigger_cmd,
  input wire logic cap_conv_done,
  input wire logic res_conv_done,
  input wire logic timer_tick,
  input wire logic run_bit_a,
  input wire logic low_freq_osc,
  input wire logic wdt_restart,
  input wire logic wdt_flag_clr,
  output logic proc_start,
  output logic bandgap_refresh,
  output logic [1:0] proc_speed,
  output logic wake_trigger_flag_n,
  output logic cap_cycle_trigger_flag_n,
  output logic res_cycle_trigger_flag_n,
  output logic wdt_por,
  output logic watchdog_reset_flag
);
  import ptwc_pkg::*;

  typedef struct packed {
    logic [7:0] r27;
    logic [7:0] r29;
    logic [7:0] r30;
    logic [7:0] r33;
    logic [7:0] r34;
    ptwc_wdt_t wdt_st;
    logic [7:0] rdata;
    logic [1:0][DEB_W-1:0] deb;
    logic [3:0] filt;
    logic [3:0] latched;
    logic [3:0] pbits;
    logic run_prev;
    logic irq_prev;
    logic [3:0] pout;
    logic [3:0] oe;
    logic [3:0] pu;
    logic pin4;
    logic pin5;
    logic start;
    logic bg;
    logic wake_n;
    logic cap_n;
    logic res_n;
    logic [1:0] lf_sync;
    logic lf_prev;
    logic [WDT_W-1:0] wdt_cnt;
    logic wdt_por;
    logic wdt_flag;
  } ptwc_state_t;

  ptwc_state_t s;
  ptwc_state_t next_s;
  logic [3:0] lset;
  logic [3:0] lclr;
  logic pin_go;
  logic cap_go;
  logic res_go;
  logic tmr_go;
  logic run_go;
  logic irq_go;
  logic lf_tick;

  function automatic logic fell_edge(input logic p, input logic c);
    return p & ~c;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.start = 1'b0;
    next_s.bg = 1'b0;
    next_s.wdt_por = 1'b0;
    // Watchdog counts regardless of processor state
    next_s.lf_sync = {s.lf_sync[0], low_freq_osc};
    next_s.lf_prev = s.lf_sync[1];
    lf_tick = s.lf_sync[1] & ~s.lf_prev;
    case (s.wdt_st)
      PTWC_WDT_ARMED: begin
        if (wdt_restart) begin
          next_s.wdt_cnt = '0;
        end else if (lf_tick) begin
          if (s.wdt_cnt == WDT_W'(WDT_TICKS - 1)) begin
            next_s.wdt_por = 1'b1;
            next_s.wdt_cnt = '0;
          end else begin
            next_s.wdt_cnt = s.wdt_cnt + WDT_W'(1);
          end
        end
      end
      PTWC_WDT_OFF: begin
        next_s.wdt_cnt = '0;
      end
      default: begin
        next_s.wdt_st = PTWC_WDT_ARMED;
        next_s.wdt_cnt = '0;
      end
    endcase
    // Set wins over the clear in the same cycle
    if (wdt_flag_clr) begin
      next_s.wdt_flag = 1'b0;
    end
    if (next_s.wdt_por) begin
      next_s.wdt_flag = 1'b1;
    end
    // ----------------------------------------------------------------
    // Register writes and reads
    // ----------------------------------------------------------------
    if (cfg_we) begin
      case (cfg_addr)
        REG_PORT_CFG: begin
          next_s.r27 = cfg_wdata;
        end
        REG_LATCH_CFG: begin
          next_s.r29 = cfg_wdata;
        end
        REG_IRQ_SRC_CFG: begin
          next_s.r30 = cfg_wdata;
        end
        REG_DIR_PU_CFG: begin
          next_s.r33 = cfg_wdata;
        end
        REG_BG_CFG: begin
          next_s.r34 = cfg_wdata;
        end
        REG_WDT_KEY: begin
          // Any other value re-arms with a fresh count
          next_s.wdt_st = (cfg_wdata == WDT_KEY) ? PTWC_WDT_OFF : PTWC_WDT_ARMED;
          next_s.wdt_cnt = '0;
        end
        default: begin
        end
      endcase
    end
    case (cfg_addr)
      REG_PORT_CFG: next_s.rdata = s.r27;
      REG_LATCH_CFG: next_s.rdata = s.r29;
      REG_IRQ_SRC_CFG: next_s.rdata = s.r30;
      REG_DIR_PU_CFG: next_s.rdata = s.r33;
      REG_BG_CFG: next_s.rdata = s.r34;
      REG_WDT_KEY: next_s.rdata = {7'h00, s.wdt_st == PTWC_WDT_OFF};
      REG_STATUS: next_s.rdata = {3'h0, s.wdt_flag, s.latched};
      default: next_s.rdata = 8'h00;
    endcase
    // ----------------------------------------------------------------
    // Debounce: first edge passes, later edges wait out the monoflop
    // ----------------------------------------------------------------
    for (int i = 0; i < 2; i++) begin
      if (s.r27[DEB_EN_LSB + i]) begin
        if (s.deb[i] != '0) begin
          next_s.deb[i] = s.deb[i] - DEB_W'(1);
        end else if (gpio_in[i] != s.filt[i]) begin
          next_s.filt[i] = gpio_in[i];
          next_s.deb[i] = DEB_W'(DEB_CYCLES - 1);
        end
      end else begin
        next_s.filt[i] = gpio_in[i];
        next_s.deb[i] = '0;
      end
    end
    next_s.filt[3:2] = gpio_in[3:2];
    // ----------------------------------------------------------------
    // Trigger latches
    // ----------------------------------------------------------------
    for (int i = 0; i < 4; i++) begin
      lset[i] = fell_edge(s.filt[i], next_s.filt[i]) & s.r29[LATCH_MASK_LSB + i]
        & s.r33[DIR_LSB + i];
      lclr[i] = fell_edge(s.pbits[i], proc_out_bits[i]) | proc_stop;
      next_s.latched[i] = (s.latched[i] & ~lclr[i]) | lset[i];
    end
    next_s.pbits = proc_out_bits[3:0];
    // ----------------------------------------------------------------
    // Processor start sources
    // ----------------------------------------------------------------
    pin_go = lset[s.r29[TRIG_PIN_LSB +: 2]];
    cap_go = cap_conv_done & s.r30[SRC_EN_LSB + SRC_CAP];
    res_go = res_conv_done & s.r30[SRC_EN_LSB + SRC_RES];
    tmr_go = timer_tick & s.r30[SRC_EN_LSB + SRC_TIMER];
    run_go = run_bit_a & ~s.run_prev;
    next_s.run_prev = run_bit_a;
    next_s.start = pin_go | cap_go | res_go | tmr_go | run_go
      | start_conv_cmd | proc_trigger_cmd;
    next_s.bg = next_s.start & s.r34[BIT_BG_EN];
    // Flags return high at stop; a new event in that cycle still lowers them
    if (proc_stop) begin
      next_s.wake_n = 1'b1;
      next_s.cap_n = 1'b1;
      next_s.res_n = 1'b1;
    end
    if (run_go) begin
      next_s.wake_n = 1'b0;
    end
    if (cap_go) begin
      next_s.cap_n = 1'b0;
    end
    if (res_go) begin
      next_s.res_n = 1'b0;
    end
    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    for (int i = 0; i < 4; i++) begin
      next_s.oe[i] = ~s.r33[DIR_LSB + i];
      next_s.pu[i] = s.r33[PU_LSB + i];
    end
    next_s.pout[0] = s.r27[BIT_PULSE_OUT_0_SEL] ? proc_out_bits[0] : pulse_out_0;
    next_s.pout[2] = s.r27[BIT_PULSE_OUT_0_SEL] ? pulse_out_0 : proc_out_bits[2];
    next_s.pout[1] = s.r27[BIT_PULSE_OUT_1_SEL] ? proc_out_bits[1] : pulse_out_1;
    next_s.pout[3] = s.r27[BIT_PULSE_OUT_1_SEL] ? pulse_out_1 : proc_out_bits[3];
    // Edge of the write, so a held strobe still gives one pulse
    irq_go = irq_write & ~s.irq_prev;
    next_s.irq_prev = irq_write;
    next_s.pin4 = s.r30[BIT_IRQ4_EN] ? ~irq_go : proc_out_bits[4];
    next_s.pin5 = s.r30[BIT_IRQ5_EN] ? ~irq_go : proc_out_bits[5];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.r27 <= RST_PORT_CFG;
      s.r29 <= RST_CFG;
      s.r30 <= RST_CFG;
      s.r33 <= RST_DIR_PU;
      s.r34 <= RST_CFG;
      s.wdt_st <= PTWC_WDT_ARMED;
      s.pin4 <= 1'b1;
      s.pin5 <= 1'b1;
      s.wake_n <= 1'b1;
      s.cap_n <= 1'b1;
      s.res_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign cfg_rdata = s.rdata;
  assign gpio_out = s.pout;
  assign gpio_oe = s.oe;
  assign gpio_pu = s.pu;
  assign gpio_pin_4 = s.pin4;
  assign gpio_pin_5 = s.pin5;
  assign proc_start = s.start;
  assign bandgap_refresh = s.bg;
  assign proc_speed = s.r27[SPEED_LSB +: 2];
  assign wake_trigger_flag_n = s.wake_n;
  assign cap_cycle_trigger_flag_n = s.cap_n;
  assign res_cycle_trigger_flag_n = s.res_n;
  assign wdt_por = s.wdt_por;
  assign watchdog_reset_flag = s.wdt_flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  chk_latch_masked: assert property (
    ((s.latched & ~$past(s.latched) & ~$past(s.r29[3:0])) == 4'h0))
    else $error("latch set on a masked pin");

  chk_bg_refresh: assert property (
    bandgap_refresh == (proc_start && $past(s.r34[BIT_BG_EN])))
    else $error("bandgap refresh does not follow start");

  chk_cmd_start: assert property (
    (proc_trigger_cmd || start_conv_cmd) |=> proc_start)
    else $error("host command did not start processor");

  chk_run_start: assert property (
    (run_bit_a && !$past(run_bit_a) && !proc_stop) |=> proc_start && !wake_trigger_flag_n)
    else $error("run bit rise did not start processor");

  chk_irq_pulse: assert property (
    (s.r30[BIT_IRQ4_EN] && irq_write && !s.irq_prev) |=> !gpio_pin_4
      ##1 (gpio_pin_4 || !s.r30[BIT_IRQ4_EN]))
    else $error("interrupt pulse on pin 4 wrong");

  chk_wdt_flag: assert property (
    (wdt_por && !wdt_flag_clr) |=> watchdog_reset_flag)
    else $error("watchdog flag not set after timeout");

  chk_wdt_off: assert property (
    (s.wdt_st == PTWC_WDT_OFF) |=> !wdt_por)
    else $error("disabled watchdog fired");

  chk_dir_pullup: assert property (
    (cfg_we && cfg_addr == REG_DIR_PU_CFG) ##1 !(cfg_we && cfg_addr == REG_DIR_PU_CFG)
      |=> gpio_oe == ~$past(cfg_wdata[7:4], 2) && gpio_pu == $past(cfg_wdata[3:0], 2))
    else $error("direction or pull-up not applied");

  chk_deb_hold: assert property (
    (s.r27[DEB_EN_LSB] && s.deb[0] != '0) |=> $stable(s.filt[0]))
    else $error("debounced input changed inside hold time");
endmodule
`default_nettype wire

//--- tb/ptwc_pin_model.sv
// Switches and pull-ups seen on port pins 0 to 3
`timescale 1ns/1ps
`default_nettype none
module ptwc_pin_model (
  input wire logic sys_clk,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe,
  input wire logic [3:0] gpio_pu,
  input wire logic [3:0] sw_on,
  input wire logic [3:0] sw_val,
  output logic [3:0] gpio_in
);
  logic [3:0] drift = 4'h0;
  // A floating pin wanders every cycle, so no stale level can pass for a real one
  always @(posedge sys_clk) drift <= ~drift;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (gpio_oe[i]) gpio_in[i] = gpio_out[i];
      else if (sw_on[i]) gpio_in[i] = sw_val[i];
      else if (gpio_pu[i]) gpio_in[i] = 1'b1;
      else gpio_in[i] = drift[i];
    end
  end
endmodule
`default_nettype wire

//--- tb/ptwc_top_tb.sv
// Self-checking bench for the port trigger and watchdog control block
`timescale 1ns/1ps
`default_nettype none
module ptwc_top_tb;
  import ptwc_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic cfg_we = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg_rdata, rd;
  logic [3:0] gpio_in, gpio_out, gpio_oe, gpio_pu;
  logic [3:0] sw_on = 4'h0;
  logic [3:0] sw_val = 4'hf;
  logic pin4, pin5, st, bg, start, bgr, por, wflag, wake_n, cap_n, res_n;
  logic [1:0] speed;
  logic p0 = 1'b0;
  logic p1 = 1'b0;
  logic lfo = 1'b0;
  logic [5:0] pob = 6'h30;
  logic [9:0] ev = 10'h000;
  logic [7:0] ra [6] = '{REG_PORT_CFG, REG_LATCH_CFG, REG_IRQ_SRC_CFG, REG_DIR_PU_CFG,
    REG_BG_CFG, 8'h50};
  logic [7:0] rv [6] = '{RST_PORT_CFG, RST_CFG, RST_CFG, RST_DIR_PU, RST_CFG, 8'h00};
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int por_n = 0;
  int k, lo4, lo5;
  always #10 sys_clk = ~sys_clk;
  ptwc_top #(.DEB_CYCLES(40), .WDT_TICKS(4)) i_ptwc_top (
    .sys_clk(sys_clk), .nrst(nrst), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .gpio_pu(gpio_pu), .gpio_pin_4(pin4), .gpio_pin_5(pin5),
    .pulse_out_0(p0), .pulse_out_1(p1), .proc_out_bits(pob), .irq_write(ev[6]),
    .proc_stop(ev[7]), .start_conv_cmd(ev[0]), .proc_trigger_cmd(ev[1]),
    .cap_conv_done(ev[2]), .res_conv_done(ev[3]), .timer_tick(ev[4]), .run_bit_a(ev[5]),
    .low_freq_osc(lfo), .wdt_restart(ev[9]), .wdt_flag_clr(ev[8]), .proc_start(start),
    .bandgap_refresh(bgr), .proc_speed(speed), .wake_trigger_flag_n(wake_n),
    .cap_cycle_trigger_flag_n(cap_n), .res_cycle_trigger_flag_n(res_n), .wdt_por(por),
    .watchdog_reset_flag(wflag));
  ptwc_pin_model i_ptwc_pin_model (.sys_clk(sys_clk), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .gpio_pu(gpio_pu), .sw_on(sw_on), .sw_val(sw_val), .gpio_in(gpio_in));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Slow oscillator, watchdog pulse count and hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) lfo <= ~lfo;
    if (por === 1'b1) por_n <= por_n + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      wrap_up();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cfg_we <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_we <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge sys_clk);
    cfg_addr <= a;
    repeat (2) @(posedge sys_clk);
    #1 rd = cfg_rdata;
  endtask
  // Looks from the launching edge on, so a one-cycle start is not missed
  task automatic watch();
    st = 1'b0;
    bg = 1'b0;
    repeat (6) begin
      #1;
      if (start === 1'b1) st = 1'b1;
      if (bgr === 1'b1) bg = 1'b1;
      @(posedge sys_clk);
    end
  endtask
  task automatic fire(input int b);
    @(posedge sys_clk);
    ev[b] <= 1'b1;
    @(posedge sys_clk);
    ev[b] <= 1'b0;
    watch();
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    for (k = 0; k < 6; k++) begin
      rdr(ra[k]);
      check("reset value", rd, rv[k]);
    end
    wr(8'h50, 8'haa);
    rdr(8'h50);
    check("unmapped", rd, 8'h00);
    wr(REG_DIR_PU_CFG, 8'h0f);
    repeat (2) @(posedge sys_clk);
    #1 check("oe and pull-up", {gpio_oe, gpio_pu}, 8'hff);
    wr(REG_DIR_PU_CFG, 8'h00);
    @(posedge sys_clk);
    p0 <= 1'b1;
    p1 <= 1'b1;
    for (k = 0; k < 2; k++) begin
      wr(REG_PORT_CFG, k ? 8'h23 : 8'h20);
      repeat (3) @(posedge sys_clk);
      #1 check("pin outputs", {gpio_oe, gpio_out}, k ? 8'hfc : 8'hf3);
    end
    for (k = 0; k < 4; k++) begin
      wr(REG_PORT_CFG, 8'(k << 4));
      repeat (2) @(posedge sys_clk);
      #1 check("speed", {6'h00, speed}, 8'(k));
    end
    wr(REG_PORT_CFG, 8'h20);
    for (k = 0; k < 2; k++) begin
      fire(k);
      check("host start", {7'h00, st}, 8'h01);
    end
    for (k = 2; k < 5; k++) begin
      wr(REG_IRQ_SRC_CFG, 8'h00);
      fire(k);
      check("disabled source", {7'h00, st}, 8'h00);
      wr(REG_IRQ_SRC_CFG, 8'(1 << (k - 2)));
      fire(k);
      check("enabled source", {7'h00, st}, 8'h01);
    end
    check("cycle flags", {6'h00, cap_n, res_n}, 8'h00);
    wr(REG_BG_CFG, 8'h01);
    fire(5);
    check("run start", {5'h00, st, bg, wake_n}, 8'h06);
    wr(REG_BG_CFG, 8'h00);
    fire(5);
    check("no refresh", {6'h00, st, bg}, 8'h02);
    fire(7);
    check("flags after stop", {5'h00, wake_n, cap_n, res_n}, 8'h07);
    for (k = 0; k < 2; k++) begin
      wr(REG_IRQ_SRC_CFG, k ? 8'h80 : 8'h40);
      lo4 = 0;
      lo5 = 0;
      @(posedge sys_clk);
      ev[6] <= 1'b1;
      repeat (5) begin
        @(posedge sys_clk);
        #1;
        if (pin4 === 1'b0) lo4++;
        if (pin5 === 1'b0) lo5++;
      end
      @(posedge sys_clk);
      ev[6] <= 1'b0;
      check("irq pulses", 8'(lo4 * 16 + lo5), k ? 8'h01 : 8'h10);
    end
    wr(REG_IRQ_SRC_CFG, 8'h00);
    wr(REG_DIR_PU_CFG, 8'hff);
    @(posedge sys_clk);
    sw_on <= 4'hf;
    wr(REG_LATCH_CFG, 8'h25);
    repeat (5) @(posedge sys_clk);
    sw_val[2] <= 1'b0;
    watch();
    check("selected latch", {7'h00, st}, 8'h01);
    sw_val[0] <= 1'b0;
    watch();
    check("other latch", {7'h00, st}, 8'h00);
    sw_val[3] <= 1'b0;
    watch();
    check("masked latch", {7'h00, st}, 8'h00);
    rdr(REG_STATUS);
    check("latches", rd & 8'h0f, 8'h05);
    pob <= 6'h35;
    @(posedge sys_clk);
    pob <= 6'h30;
    rdr(REG_STATUS);
    check("latch clear", rd & 8'h0f, 8'h00);
    sw_val <= 4'hf;
    wr(REG_LATCH_CFG, 8'h01);
    wr(REG_PORT_CFG, 8'he0);
    repeat (50) @(posedge sys_clk);
    sw_val[0] <= 1'b0;
    watch();
    check("first edge", {7'h00, st}, 8'h01);
    pob <= 6'h31;
    @(posedge sys_clk);
    pob <= 6'h30;
    @(posedge sys_clk);
    sw_val[0] <= 1'b1;
    @(posedge sys_clk);
    sw_val[0] <= 1'b0;
    watch();
    check("bounce", {7'h00, st}, 8'h00);
    sw_val[0] <= 1'b1;
    repeat (100) @(posedge sys_clk);
    sw_val[0] <= 1'b0;
    watch();
    check("after hold", {7'h00, st}, 8'h01);
    fire(7);
    rdr(REG_STATUS);
    check("latch stop", rd & 8'h0f, 8'h00);
    wr(REG_WDT_KEY, 8'h00);
    fire(8);
    k = por_n;
    // Shorter than two timeouts, so exactly one reset falls inside
    repeat (40) @(posedge sys_clk);
    check("watchdog resets", 8'(por_n - k), 8'h01);
    rdr(REG_STATUS);
    check("watchdog flag", {3'h0, rd[4], 3'h0, wflag}, 8'h11);
    ev[9] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    k = por_n;
    repeat (40) @(posedge sys_clk);
    ev[9] <= 1'b0;
    check("restart holds off", 8'(por_n - k), 8'h00);
    wr(REG_WDT_KEY, WDT_KEY);
    fire(8);
    k = por_n;
    repeat (100) @(posedge sys_clk);
    rdr(REG_WDT_KEY);
    check("disabled", {rd[0], 6'h00, wflag}, 8'h80);
    check("no resets", 8'(por_n - k), 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
